// ==== src/touch_decision.sv ====
`timescale 1ns/100ps
// Contract
// - Report field 00 reports everything; 01 reports only the first touched button.
// - Interrupt field gates events: 00 none, 01 touch, 10 release, 11 both.
// - Touch debounce code n needs n+1 consecutive qualifying samples.
// - Release debounce code n needs n+1 consecutive qualifying samples.
// - Debounce counts one sample per scan period before deciding.
// - Touch counting starts when ticks exceed threshold plus hysteresis.
// - Release qualifies when ticks fall below threshold minus hysteresis.
// - Hysteresis is a shared percentage of each threshold, 0 to 100.
// - Averaging is suspended while ticks exceed four times the averaging level.
// - Negative compensation level is four ticks per step, 0 to 1020.
// - Negative sample limit sets samples needed to start compensation.
// - Held timeout in seconds; zero disables it.
// - Timeout forces release; new touch only after ticks reach release level.
// - Negative counter increments below level; reaching limit triggers compensation.
// - Three or more pins above four times the averaging level in one scan trigger compensation.
module touch_decision #(
   parameter int N = 12,
   parameter int TICK_W = 16,
   parameter int SEC_CYCLES = touch_pkg::SECOND_CYCLES
) (
   // Clock, enable and reset
   input wire logic clk,
   input wire logic ce,
   input wire logic rst_b,
   // Register port
   input wire logic [7:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rd_data,
   // Tick samples, one per pin per scan
   input wire logic tick_valid,
   input wire logic [$clog2(N)-1:0] tick_pin,
   input wire logic signed [TICK_W-1:0] tick_value,
   input wire logic tick_last,
   // Results
   output logic [N-1:0] touch_state,
   output logic [N-1:0] avg_suspend,
   output logic comp_start,
   output logic irq
);
   localparam int AW = $clog2(N);

   if (N < 2 || N > 16 || TICK_W < 12 || TICK_W > 24 || SEC_CYCLES < 1) begin : g_check
      $error("touch_decision: unsupported parameter values");
   end

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic [N-1:0] touched;
      logic [N-1:0] stuck_wait;
      logic [N-1:0][1:0] deb;
      logic [N-1:0][7:0] neg;
      logic [N-1:0][7:0] held;
      logic owner_valid;
      logic [AW-1:0] owner;
      logic [31:0] sec_cnt;
      logic [4:0] crowd;
      logic p_valid;
      logic p_last;
      logic [AW-1:0] p_pin;
      logic signed [TICK_W-1:0] p_tick;
      logic [7:0] event_config;
      logic [7:0] avg_level;
      logic [7:0] neg_level;
      logic [7:0] neg_limit;
      logic [7:0] hyst;
      logic [7:0] timeout;
      logic [2:0] status;
      logic [2:0] mask;
      logic [7:0] rd_reg;
      logic rd_mem;
      logic [N-1:0] avg_suspend;
      logic comp_start;
      logic irq;
   } state_t;

   state_t s;
   state_t next_s;
   level_store_if #(.N(N), .AW(AW)) lvl ();

   level_store #(.N(N), .AW(AW)) u_levels (
      .clk(clk),
      .rst_b(rst_b),
      .port(lvl)
   );

   function automatic logic count_done(input logic [1:0] cnt, input logic [1:0] code);
      return cnt >= code;
   endfunction

   // ****************************************************************
   // Decision datapath
   // ****************************************************************
   logic [15:0] hyst_amt;
   logic signed [TICK_W+2:0] tick_x;
   logic signed [TICK_W+2:0] upper;
   logic signed [TICK_W+2:0] lower;
   logic signed [TICK_W+2:0] avg_ticks;
   logic signed [TICK_W+2:0] neg_ticks;
   logic above;
   logic below;
   logic over_avg;
   logic under_neg;
   logic single_mode;
   logic blocked;
   logic ev_touch;
   logic ev_release;
   logic ev_stuck;
   logic neg_trig;
   logic crowd_trig;
   logic sec_pulse;
   logic [15:0] touch_pad;
   logic mem_hit;

   always_comb begin
      logic [7:0] pct;
      pct = (s.hyst > touch_pkg::HYST_MAX) ? touch_pkg::HYST_MAX : s.hyst;
      hyst_amt = 16'((16'(lvl.scan_data) * 16'(pct)) / 16'd100);
   end

   assign tick_x = (TICK_W+3)'(s.p_tick);
   assign upper = (TICK_W+3)'(lvl.scan_data) + (TICK_W+3)'(hyst_amt);
   assign lower = (TICK_W+3)'(lvl.scan_data) - (TICK_W+3)'(hyst_amt);
   assign avg_ticks = (TICK_W+3)'(s.avg_level) <<< touch_pkg::LEVEL_STEP_SHIFT;
   assign neg_ticks = -((TICK_W+3)'(s.neg_level) <<< touch_pkg::LEVEL_STEP_SHIFT);
   assign above = tick_x > upper;
   assign below = tick_x < lower;
   assign over_avg = tick_x > avg_ticks;
   assign under_neg = tick_x < neg_ticks;
   assign single_mode = s.event_config[touch_pkg::REPORT_LSB +: 2] == touch_pkg::REPORT_SINGLE;
   assign sec_pulse = s.sec_cnt == 32'(SEC_CYCLES - 1);
   assign mem_hit = addr >= touch_pkg::LEVEL_BASE && addr < touch_pkg::LEVEL_BASE + 8'(N);

   // other buttons ignored while first one is held
   assign blocked = single_mode && s.owner_valid && s.owner != s.p_pin;

   always_comb begin
      ev_touch = 1'b0;
      ev_release = 1'b0;
      ev_stuck = 1'b0;
      if (s.p_valid && !blocked) begin
         if (!s.touched[s.p_pin]) begin
            ev_touch = above && !s.stuck_wait[s.p_pin]
                       && count_done(s.deb[s.p_pin], s.event_config[touch_pkg::TOUCH_DEB_LSB +: 2]);
         end else if (s.timeout != 8'h00 && s.held[s.p_pin] >= s.timeout) begin
            ev_stuck = 1'b1;
         end else begin
            ev_release = below && count_done(s.deb[s.p_pin],
                                             s.event_config[touch_pkg::RELEASE_DEB_LSB +: 2]);
         end
      end
   end

   assign neg_trig = s.p_valid && under_neg && s.neg_limit != 8'h00
                     && (s.neg[s.p_pin] + 8'h01) >= s.neg_limit;
   assign crowd_trig = s.p_valid && s.p_last
                       && (s.crowd + 5'(over_avg)) >= 5'(touch_pkg::CROWD_MIN);

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      logic [2:0] ev;
      next_s = s;
      ev = 3'h0;
      next_s.p_valid = tick_valid && 32'(tick_pin) < N;
      next_s.p_last = tick_last;
      next_s.p_pin = tick_pin;
      next_s.p_tick = tick_value;
      next_s.sec_cnt = sec_pulse ? 32'h0 : s.sec_cnt + 32'h1;
      next_s.comp_start = 1'b0;
      for (int i = 0; i < N; i++) begin
         if (sec_pulse && s.touched[i] && s.held[i] != 8'hff) begin
            next_s.held[i] = s.held[i] + 8'h01;
         end
      end
      if (s.p_valid) begin
         next_s.avg_suspend[s.p_pin] = over_avg;
         next_s.neg[s.p_pin] = neg_trig ? 8'h00
                             : under_neg ? ((s.neg[s.p_pin] == 8'hff) ? 8'hff
                                            : s.neg[s.p_pin] + 8'h01) : 8'h00;
         next_s.crowd = s.p_last ? 5'h0 : s.crowd + 5'(over_avg);
         if (!blocked) begin
            if (ev_touch || ev_release || ev_stuck) begin
               next_s.deb[s.p_pin] = 2'h0;
            end else if ((!s.touched[s.p_pin] && above && !s.stuck_wait[s.p_pin])
                         || (s.touched[s.p_pin] && below)) begin
               next_s.deb[s.p_pin] = s.deb[s.p_pin] + 2'h1;
            end else begin
               next_s.deb[s.p_pin] = 2'h0;
            end
         end
         // real release needed before next touch
         if (s.stuck_wait[s.p_pin] && below) begin
            next_s.stuck_wait[s.p_pin] = 1'b0;
         end
         if (ev_touch) begin
            next_s.touched[s.p_pin] = 1'b1;
            next_s.held[s.p_pin] = 8'h00;
            if (single_mode) begin
               next_s.owner_valid = 1'b1;
               next_s.owner = s.p_pin;
            end
         end
         if (ev_release || ev_stuck) begin
            next_s.touched[s.p_pin] = 1'b0;
            next_s.stuck_wait[s.p_pin] = ev_stuck;
            if (s.owner_valid && s.owner == s.p_pin) begin
               next_s.owner_valid = 1'b0;
            end
         end
         if (neg_trig || crowd_trig) begin
            next_s.comp_start = 1'b1;
         end
      end
      ev[touch_pkg::ST_TOUCH] = ev_touch && s.event_config[touch_pkg::IRQ_TOUCH_BIT];
      ev[touch_pkg::ST_RELEASE] = (ev_release || ev_stuck)
                                  && s.event_config[touch_pkg::IRQ_RELEASE_BIT];
      ev[touch_pkg::ST_COMP] = next_s.comp_start;
      if (wr) begin
         unique case (addr)
            touch_pkg::EVENT_CONFIG_ADDR: next_s.event_config = wr_data;
            touch_pkg::AVG_LEVEL_ADDR: next_s.avg_level = wr_data;
            touch_pkg::NEG_LEVEL_ADDR: next_s.neg_level = wr_data;
            touch_pkg::NEG_LIMIT_ADDR: next_s.neg_limit = wr_data;
            touch_pkg::HYST_ADDR: next_s.hyst = wr_data;
            touch_pkg::TIMEOUT_ADDR: next_s.timeout = wr_data;
            touch_pkg::IRQ_STATUS_ADDR: next_s.status = s.status & ~wr_data[2:0];
            touch_pkg::IRQ_MASK_ADDR: next_s.mask = wr_data[2:0];
            default: ;
         endcase
      end
      // owner dropped with single mode
      // A switch away from single reporting drops the owner with the same write.
      if (next_s.event_config[touch_pkg::REPORT_LSB +: 2] != touch_pkg::REPORT_SINGLE) begin
         next_s.owner_valid = 1'b0;
      end
      // New events win over a clear in the same cycle.
      next_s.status = next_s.status | ev;
      next_s.irq = |(next_s.status & next_s.mask);
      touch_pad = 16'(s.touched);
      next_s.rd_mem = rd && mem_hit;
      next_s.rd_reg = 8'h00;
      if (rd) begin
         unique case (addr)
            touch_pkg::EVENT_CONFIG_ADDR: next_s.rd_reg = s.event_config;
            touch_pkg::AVG_LEVEL_ADDR: next_s.rd_reg = s.avg_level;
            touch_pkg::NEG_LEVEL_ADDR: next_s.rd_reg = s.neg_level;
            touch_pkg::NEG_LIMIT_ADDR: next_s.rd_reg = s.neg_limit;
            touch_pkg::HYST_ADDR: next_s.rd_reg = s.hyst;
            touch_pkg::TIMEOUT_ADDR: next_s.rd_reg = s.timeout;
            touch_pkg::IRQ_STATUS_ADDR: next_s.rd_reg = {5'h00, s.status};
            touch_pkg::IRQ_MASK_ADDR: next_s.rd_reg = {5'h00, s.mask};
            touch_pkg::TOUCH_LO_ADDR: next_s.rd_reg = touch_pad[7:0];
            touch_pkg::TOUCH_HI_ADDR: next_s.rd_reg = touch_pad[15:8];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s <= '0;
         s.event_config <= touch_pkg::EVENT_CONFIG_RESET;
         s.avg_level <= touch_pkg::AVG_LEVEL_RESET;
         s.neg_level <= touch_pkg::NEG_LEVEL_RESET;
         s.neg_limit <= touch_pkg::NEG_LIMIT_RESET;
         s.hyst <= touch_pkg::HYST_RESET;
         s.timeout <= touch_pkg::TIMEOUT_RESET;
         s.mask <= touch_pkg::IRQ_MASK_RESET;
      end else if (ce) begin
         s <= next_s;
      end
   end

   // ****************************************************************
   // Threshold store and outputs
   // ****************************************************************
   assign lvl.ce = ce;
   assign lvl.we = wr && mem_hit;
   assign lvl.waddr = AW'(addr - touch_pkg::LEVEL_BASE);
   assign lvl.wdata = wr_data;
   assign lvl.scan_addr = tick_pin;
   assign lvl.bus_addr = AW'(addr - touch_pkg::LEVEL_BASE);

   // Threshold reads come from the store's own output register.
   assign rd_data = s.rd_mem ? lvl.bus_data : s.rd_reg;
   assign touch_state = s.touched;
   assign avg_suspend = s.avg_suspend;
   assign comp_start = s.comp_start;
   assign irq = s.irq;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   a_single_owner: assert property (s.owner_valid |-> s.touched[s.owner] && single_mode)
      else $error("owner button not held");
   a_irq_touch_gate: assert property (ce && ev_touch && !s.event_config[4] && !s.status[0]
                                      |=> !s.status[0])
      else $error("touch flagged while masked");
   a_touch_count: assert property (ev_touch |-> s.deb[s.p_pin] == s.event_config[1:0])
      else $error("touch declared at wrong count");
   a_release_count: assert property (ev_release |-> s.deb[s.p_pin] == s.event_config[3:2])
      else $error("release declared at wrong count");
   a_touch_level: assert property (ev_touch |-> above)
      else $error("touch without exceeding level");
   a_release_level: assert property (ev_release |-> below)
      else $error("release without falling below level");
   a_hyst_bound: assert property (s.p_valid |-> hyst_amt <= 16'(lvl.scan_data))
      else $error("hysteresis above threshold");
   a_stuck_block: assert property (s.p_valid && s.stuck_wait[s.p_pin] |-> !ev_touch)
      else $error("touch accepted before real release");
   a_comp_cause: assert property (ce && s.p_valid && (neg_trig || crowd_trig)
                                  |=> comp_start ##1 (!comp_start || !$past(ce)
                                      || $past(ce && s.p_valid && (neg_trig || crowd_trig))))
      else $error("compensation pulse missing");
   a_timeout_off: assert property (s.timeout == 8'h00 |-> !ev_stuck)
      else $error("timeout release while disabled");

   c_touch: cover property (ev_touch);
   c_release: cover property (ev_release);
   c_stuck: cover property (ev_stuck);
   c_comp: cover property (comp_start);
endmodule

// ==== src/touch_pkg.sv ====
package touch_pkg;
   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam logic [7:0] LEVEL_BASE = 8'h13;
   localparam logic [7:0] EVENT_CONFIG_ADDR = 8'h21;
   localparam logic [7:0] AVG_LEVEL_ADDR = 8'h22;
   localparam logic [7:0] NEG_LEVEL_ADDR = 8'h23;
   localparam logic [7:0] NEG_LIMIT_ADDR = 8'h24;
   localparam logic [7:0] HYST_ADDR = 8'h25;
   localparam logic [7:0] TIMEOUT_ADDR = 8'h26;
   localparam logic [7:0] IRQ_STATUS_ADDR = 8'h30;
   localparam logic [7:0] IRQ_MASK_ADDR = 8'h31;
   localparam logic [7:0] TOUCH_LO_ADDR = 8'h32;
   localparam logic [7:0] TOUCH_HI_ADDR = 8'h33;

   // ****************************************************************
   // Fields and reset values
   // ****************************************************************
   localparam int TOUCH_DEB_LSB = 0;
   localparam int RELEASE_DEB_LSB = 2;
   localparam int IRQ_TOUCH_BIT = 4;
   localparam int IRQ_RELEASE_BIT = 5;
   localparam int REPORT_LSB = 6;
   localparam logic [1:0] REPORT_SINGLE = 2'h1;
   localparam logic [7:0] EVENT_CONFIG_RESET = 8'h30;
   localparam logic [7:0] AVG_LEVEL_RESET = 8'h50;
   localparam logic [7:0] NEG_LEVEL_RESET = 8'h50;
   localparam logic [7:0] NEG_LIMIT_RESET = 8'h01;
   localparam logic [7:0] HYST_RESET = 8'h0a;
   localparam logic [7:0] TIMEOUT_RESET = 8'h00;
   localparam logic [7:0] HYST_MAX = 8'h64;
   localparam logic [7:0] LEVEL_RESET = 8'h00;
   localparam logic [2:0] IRQ_MASK_RESET = 3'h7;
   localparam int ST_TOUCH = 0;
   localparam int ST_RELEASE = 1;
   localparam int ST_COMP = 2;
   localparam int LEVEL_STEP_SHIFT = 2;
   localparam int CROWD_MIN = 3;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam longint CLK_PERIOD_NS = 5;
   localparam longint SECOND_NS = 1000000000;
   localparam int SECOND_CYCLES = int'(SECOND_NS / CLK_PERIOD_NS);
endpackage

// ==== src/level_store_if.sv ====
`timescale 1ns/100ps
interface level_store_if #(
   parameter int N = 12,
   parameter int AW = 4
);
   logic ce;
   logic we;
   logic [AW-1:0] waddr;
   logic [7:0] wdata;
   logic [AW-1:0] scan_addr;
   logic [7:0] scan_data;
   logic [AW-1:0] bus_addr;
   logic [7:0] bus_data;
   modport mem (input ce, we, waddr, wdata, scan_addr, bus_addr, output scan_data, bus_data);
   modport user (output ce, we, waddr, wdata, scan_addr, bus_addr, input scan_data, bus_data);
endinterface

// ==== src/level_store.sv ====
`timescale 1ns/100ps
module level_store #(
   parameter int N = 12,
   parameter int AW = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Access ports
   level_store_if.mem port
);
   typedef struct packed {
      logic [N-1:0][7:0] cells;
      logic [7:0] scan_data;
      logic [7:0] bus_data;
   } store_t;

   store_t s;
   store_t next_s;

   always_comb begin
      next_s = s;
      if (port.we && 32'(port.waddr) < N) begin
         next_s.cells[port.waddr] = port.wdata;
      end
      next_s.scan_data = (32'(port.scan_addr) < N) ? s.cells[port.scan_addr] : 8'h00;
      next_s.bus_data = (32'(port.bus_addr) < N) ? s.cells[port.bus_addr] : 8'h00;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s <= '0;
         s.cells <= {N{touch_pkg::LEVEL_RESET}};
      end else if (port.ce) begin
         s <= next_s;
      end
   end

   assign port.scan_data = s.scan_data;
   assign port.bus_data = s.bus_data;
endmodule

// ==== sim/button_touch_release_decision_tb.sv ====
`timescale 1ns/100ps
module button_touch_release_decision_tb;
   // ****************************************************************
   // Bench signals
   // ****************************************************************
   localparam int N = 12;
   localparam int SEC = 20;
   logic clk = 1'b0;
   logic ce = 1'b1;
   logic rst_b = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wr_data = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] rd_data;
   logic tick_valid = 1'b0;
   logic [3:0] tick_pin = 4'h0;
   logic signed [15:0] tick_value = 16'sh0000;
   logic tick_last = 1'b0;
   logic [N-1:0] touch_state;
   logic [N-1:0] avg_suspend;
   logic comp_start;
   logic irq;
   int n_fail = 0;
   int checks_done = 0;
   logic [31:0] rng = 32'h4ae49077;
   logic [31:0] r32;
   logic [7:0] rv;
   logic cs;
   int p;
   int d;
   int k;
   int hi;
   int lo;
   logic [7:0] ra[9] = '{8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h31, 8'h13, 8'h40};
   logic [7:0] rr[9] = '{8'h30, 8'h50, 8'h50, 8'h01, 8'h0a, 8'h00, 8'h07, 8'h00, 8'h00};
   logic [7:0] hs[3] = '{8'h00, 8'h64, 8'h0a};

   // The second-long held timeout is shortened to SEC cycles.
   touch_decision #(.N(N), .TICK_W(16), .SEC_CYCLES(SEC)) i_dut (
      .clk(clk), .ce(ce), .rst_b(rst_b), .addr(addr), .wr_data(wr_data), .wr(wr), .rd(rd),
      .rd_data(rd_data), .tick_valid(tick_valid), .tick_pin(tick_pin),
      .tick_value(tick_value), .tick_last(tick_last), .touch_state(touch_state),
      .avg_suspend(avg_suspend), .comp_start(comp_start), .irq(irq)
   );

   always #2.5 clk = ~clk;

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic [31:0] rnd();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction

   // Percentages above 100 are clamped, so the band never goes past zero.
   function automatic int upper(int thr, int h);
      return thr + thr * (h > 100 ? 100 : h) / 100;
   endfunction

   function automatic int lower(int thr, int h);
      return thr - thr * (h > 100 ? 100 : h) / 100;
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic wreg(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wr_data <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rreg(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      v = rd_data;
   endtask

   // Results land one edge after the edge that takes the sample.
   task automatic smp(input int pin, input int val, input logic last);
      @(posedge clk);
      tick_valid <= 1'b1;
      tick_pin <= 4'(pin);
      tick_value <= 16'(val);
      tick_last <= last;
      @(posedge clk);
      tick_valid <= 1'b0;
      tick_last <= 1'b0;
      // The compensation pulse stands for one cycle only, so it is caught at once.
      @(posedge clk);
      #1;
      cs = comp_start;
      @(posedge clk);
      #1;
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   initial begin
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      for (p = 0; p < 9; p++) begin
         rreg(ra[p], rv);
         check(rv, rr[p], "reset value");
      end
      for (p = 1; p < 6; p++) begin
         r32 = rnd();
         wreg(ra[p], r32[7:0]);
         rreg(ra[p], rv);
         check(rv, r32[7:0], "read back");
         wreg(ra[p], rr[p]);
      end
      @(posedge clk);
      ce <= 1'b0;
      wreg(touch_pkg::AVG_LEVEL_ADDR, 8'hff);
      ce <= 1'b1;
      rreg(touch_pkg::AVG_LEVEL_ADDR, rv);
      check(rv, 8'h50, "frozen write");
      for (p = 0; p < N; p++) begin
         wreg(touch_pkg::LEVEL_BASE + 8'(p), 8'h64);
      end
      p = int'(rnd() % 12);
      foreach (hs[j]) begin
         wreg(touch_pkg::HYST_ADDR, hs[j]);
         smp(p, upper(100, hs[j]), 1'b0);
         check(touch_state[p], 0, "at upper");
         smp(p, upper(100, hs[j]) + 1, 1'b0);
         check(touch_state[p], 1, "over upper");
         smp(p, lower(100, hs[j]), 1'b0);
         check(touch_state[p], 1, "at lower");
         smp(p, lower(100, hs[j]) - 1, 1'b0);
         check(touch_state[p], 0, "under lower");
      end
      smp(12, 500, 1'b0);
      check(touch_state, 0, "pin out of range");
      hi = upper(100, 10);
      lo = lower(100, 10);
      for (d = 0; d < 4; d++) begin
         wreg(touch_pkg::EVENT_CONFIG_ADDR, 8'h30 | 8'(d) | 8'(d << 2));
         p = int'(rnd() % 12);
         for (k = 0; k < d; k++) smp(p, hi + 1 + int'(rnd() % 200), 1'b0);
         if (d > 0) smp(p, lo + 5, 1'b0);
         for (k = 0; k <= d; k++) begin
            check(touch_state[p], 0, "touch early");
            smp(p, hi + 1 + int'(rnd() % 200), 1'b0);
         end
         check(touch_state[p], 1, "touch count");
         for (k = 0; k <= d; k++) begin
            check(touch_state[p], 1, "release early");
            smp(p, int'(rnd() % 90), 1'b0);
         end
         check(touch_state[p], 0, "release count");
      end
      for (d = 0; d < 4; d++) begin
         wreg(touch_pkg::EVENT_CONFIG_ADDR, 8'(d << 4));
         wreg(touch_pkg::IRQ_STATUS_ADDR, 8'h07);
         smp(p, 300, 1'b0);
         check(irq, d & 1, "irq on touch");
         rreg(touch_pkg::IRQ_STATUS_ADDR, rv);
         check(rv[0], d & 1, "touch status");
         wreg(touch_pkg::IRQ_STATUS_ADDR, 8'h01);
         smp(p, 0, 1'b0);
         check(irq, (d >> 1) & 1, "irq on release");
      end
      wreg(touch_pkg::EVENT_CONFIG_ADDR, 8'h30);
      wreg(touch_pkg::IRQ_STATUS_ADDR, 8'h07);
      wreg(touch_pkg::IRQ_MASK_ADDR, 8'h00);
      smp(p, 300, 1'b0);
      check(irq, 0, "masked irq");
      wreg(touch_pkg::IRQ_MASK_ADDR, 8'h01);
      repeat (2) @(posedge clk);
      #1;
      check(irq, 1, "unmasked irq");
      wreg(touch_pkg::IRQ_STATUS_ADDR, 8'h01);
      repeat (2) @(posedge clk);
      #1;
      check(irq, 0, "cleared irq");
      wreg(touch_pkg::IRQ_MASK_ADDR, 8'h07);
      smp(p, 0, 1'b0);
      wreg(touch_pkg::EVENT_CONFIG_ADDR, 8'h70);
      smp(0, 300, 1'b0);
      smp(1, 300, 1'b0);
      check(touch_state[1:0], 2'h1, "first owner only");
      smp(1, 0, 1'b0);
      smp(0, 0, 1'b0);
      smp(1, 300, 1'b0);
      smp(0, 300, 1'b0);
      check(touch_state[1:0], 2'h2, "new owner");
      smp(1, 0, 1'b0);
      wreg(touch_pkg::EVENT_CONFIG_ADDR, 8'hb0);
      smp(0, 300, 1'b0);
      smp(1, 300, 1'b0);
      check(touch_state[1:0], 2'h3, "reserved as multi");
      rreg(touch_pkg::TOUCH_LO_ADDR, rv);
      check(rv, 8'h03, "touch low byte");
      rreg(touch_pkg::TOUCH_HI_ADDR, rv);
      check(rv, 8'h00, "touch high byte");
      smp(0, 0, 1'b0);
      smp(1, 0, 1'b1);
      smp(2, 321, 1'b0);
      smp(3, 321, 1'b0);
      smp(4, 0, 1'b1);
      check(cs, 0, "two pins high");
      smp(2, 321, 1'b0);
      smp(3, 321, 1'b0);
      smp(4, 321, 1'b1);
      check(cs, 1, "three pins high");
      check(avg_suspend[4:2], 3'h7, "suspend set");
      for (k = 2; k < 5; k++) smp(k, 320, 1'b1);
      check(avg_suspend[4:2], 3'h0, "suspend at level");
      for (k = 2; k < 5; k++) smp(k, 0, 1'b1);
      wreg(touch_pkg::NEG_LEVEL_ADDR, 8'h02);
      wreg(touch_pkg::NEG_LIMIT_ADDR, 8'h02);
      smp(5, -8, 1'b0);
      check(cs, 0, "at negative level");
      smp(5, -9, 1'b0);
      check(cs, 0, "first negative");
      smp(5, -9, 1'b0);
      check(cs, 1, "negative limit");
      rreg(touch_pkg::IRQ_STATUS_ADDR, rv);
      check(rv[2], 1, "comp status");
      wreg(touch_pkg::NEG_LEVEL_ADDR, 8'h50);
      wreg(touch_pkg::NEG_LIMIT_ADDR, 8'h01);
      wreg(touch_pkg::TIMEOUT_ADDR, 8'h01);
      wreg(touch_pkg::IRQ_STATUS_ADDR, 8'h07);
      smp(6, 300, 1'b0);
      check(touch_state[6], 1, "held touch");
      // The forced release is decided on a sample, so the pin keeps being scanned.
      for (k = 0; k < 40 && touch_state[6] === 1'b1; k++) smp(6, 300, 1'b0);
      check(k >= 1 && k <= SEC / 4 + 2, 1, "held timeout");
      rreg(touch_pkg::IRQ_STATUS_ADDR, rv);
      check(rv[1], 1, "forced release event");
      smp(6, 300, 1'b0);
      check(touch_state[6], 0, "no retouch while held");
      smp(6, 0, 1'b0);
      smp(6, 300, 1'b0);
      check(touch_state[6], 1, "retouch after release");
      wreg(touch_pkg::TIMEOUT_ADDR, 8'h00);
      smp(6, 0, 1'b0);
      close_out();
   end

   // A hang anywhere counts as a mismatch.
   initial begin
      repeat (100000) @(posedge clk);
      n_fail++;
      close_out();
   end
endmodule
